// ==== dtl_defs.vh ====
// Purpose: Shared constants of the dither, sample marker and link control
//          register bank.
// Assumes: Register offsets are word indexes; byte address is four times.
// Notes:   Definitions only; included by the marker pipe and the register bank, not by the Wishbone port.
`ifndef DTL_DEFS_VH
`define DTL_DEFS_VH

// Register indexes on the control port.
`define DTL_IDX_DITHER       12'h009D
`define DTL_IDX_MARKER       12'h0160
`define DTL_IDX_SYNC_RX      12'h0161
`define DTL_IDX_LINK_EN      12'h0200
`define DTL_IDX_LINK_MODE    12'h0201
`define DTL_IDX_LINK_STATUS  12'h0210

// Reset values of the stored registers.
`define DTL_RST_DITHER       8'h01
`define DTL_RST_MARKER       8'h00
`define DTL_RST_SYNC_RX      8'h00
`define DTL_RST_LINK_EN      8'h01
`define DTL_RST_LINK_MODE    8'h02

// Field positions.
`define DTL_BIT_DITH_EN      0
`define DTL_BIT_DITH_AMP     1
`define DTL_BIT_DITH_ERR     2
`define DTL_BIT_MARK_EN      0
`define DTL_BIT_SYNC_RX_EN   0
`define DTL_BIT_LINK_EN      0

// Delay line stages of the sample datapath in clock cycles, after pin alignment, before the output stage.
`define DTL_PIPE_STAGES      4
// Frames per multiframe of the local multiframe counter.
`define DTL_MF_FRAMES        8'h20
// Control bits per sample advertised in the lane alignment sequence.
`define DTL_ILA_CS           2'h0

`endif

// ==== dtl_wb_port.v ====
// Purpose: Classic Wishbone slave handshake for the control register bank.
// Assumes: Single-cycle classic transfers; 32-bit data, byte lane 0 used.
// Notes:   Acknowledges every access one cycle after the request, mapped
//          or not, so a stray address can never hang the bus.
`timescale 1ns/1ns
module dtl_wb_port (
	input  wire        clk,      // System clock.
	input  wire        rst,      // Synchronous reset, active high.
	input  wire        ce,       // Clock enable; state frozen while low.
	input  wire        wb_cyc_i, // Bus cycle.
	input  wire        wb_stb_i, // Strobe.
	input  wire        wb_we_i,  // Write enable.
	input  wire [3:0]  wb_sel_i, // Byte selects.
	input  wire [31:0] rd_word,  // Read data of the addressed register.
	output reg         wb_ack_o, // Acknowledge.
	output reg  [31:0] wb_dat_o, // Read data.
	output wire        wr_stb    // One-cycle write strobe for lane 0.
);

	// The write lands on the edge at which the master samples ack high.
	assign wr_stb = ce & wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o &
		wb_sel_i[0];

	// Ack rises one cycle after the request and drops the cycle after.
	always @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce) begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i) begin
				wb_dat_o <= rd_word;
			end
		end
	end

endmodule

// ==== dtl_marker_pipe.v ====
// Purpose: Sample datapath delay line that carries the timestamp marker.
// Assumes: Marker and sample enter in the same cycle, already aligned.
// Notes:   One shift chain holds data, valid and marker together, so the
//          marker can never drift from its sample.
`timescale 1ns/1ns
`include "dtl_defs.vh"
module dtl_marker_pipe (
	input  wire        clk,     // System clock.
	input  wire        rst,     // Synchronous reset, active high.
	input  wire        ce,      // Clock enable.
	input  wire [11:0] din,     // Sample in.
	input  wire        din_vld, // Sample valid in.
	input  wire        mark_in, // Marker in.
	output wire [11:0] dout,    // Sample out.
	output wire        dout_vld,// Sample valid out.
	output wire        mark_out // Marker out.
);

	wire [13:0] stage [0:`DTL_PIPE_STAGES];
	assign stage[0] = {mark_in, din_vld, din};

	genvar g;
	generate
		for (g = 0; g < `DTL_PIPE_STAGES; g = g + 1) begin : g_stage
			reg [13:0] q;
			// Each stage moves sample, valid and marker as one word.
			always @(posedge clk) begin
				if (rst) begin
					q <= 14'h0000;
				end else if (ce) begin
					q <= stage[g];
				end
			end
			assign stage[g+1] = q;
		end
	endgenerate

	assign dout     = stage[`DTL_PIPE_STAGES][11:0];
	assign dout_vld = stage[`DTL_PIPE_STAGES][12];
	assign mark_out = stage[`DTL_PIPE_STAGES][13];

endmodule

// ==== dtl_ctrl.v ====
// Purpose: Dither, sample marker and serial link enable register bank,
//          with the sample marker path and the link gating it steers.
// Assumes: Samples arrive on clk; timestamp and sysref are pins.
// Notes:   Registers sit on classic Wishbone at four times their index.
//
// Contract
// - Dither enable bit 0 turns converter dither on.
// - Amplitude bit 1: zero small dither, one large dither.
// - Bit 2 steers rounding error: zero to SNR, one to offset/spurs.
// - Marker enable bit 0 sends timestamp on every output sample LSB.
// - Marker delayed by exactly the sample datapath latency.
// - Marker replaces lowest sample bit: 8-bit keeps 7, 12-bit keeps 11.
// - Marker never advertised as control bit; ILA control bits stay zero.
// - Link enable bit 0: zero off, one on; resets to enabled.
// - Link disabled holds the whole link block in reset.
// - Link disabled powers down serializers and gates link clocks.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ns
`include "dtl_defs.vh"
module dtl_ctrl (
	input  wire        clk,          // System clock, 250 MHz.
	input  wire        rst,          // Synchronous reset, active high.
	input  wire        ce,           // Clock enable; freezes all state.
	input  wire        wb_cyc_i,     // Wishbone cycle.
	input  wire        wb_stb_i,     // Wishbone strobe.
	input  wire        wb_we_i,      // Wishbone write enable.
	input  wire [13:0] wb_adr_i,     // Wishbone byte address.
	input  wire [3:0]  wb_sel_i,     // Wishbone byte selects.
	input  wire [31:0] wb_dat_i,     // Wishbone write data.
	output wire [31:0] wb_dat_o,     // Wishbone read data.
	output wire        wb_ack_o,     // Wishbone acknowledge.
	input  wire [11:0] sample_in,    // Converter sample, same clock.
	input  wire        sample_vld,   // Sample valid, same clock.
	input  wire        fmt_8bit,     // Output format is 8-bit samples.
	input  wire        timestamp_pin,// Timestamp input pin.
	input  wire        sysref_pin,   // SYSREF input pin.
	output reg  [11:0] sample_out,   // Output sample with marker.
	output reg         sample_out_vld,// Output sample valid.
	output reg         dither_en,    // Dither on.
	output reg         dither_large, // Large dither selected.
	output reg         err_to_offset,// Rounding error into offset/spurs.
	output reg         sync_rx_en,   // Sync receiver enable.
	output reg  [1:0]  ila_ctrl_bits,// Control bits per sample for ILA.
	output reg  [7:0]  link_mode,    // Link mode selection.
	output reg         link_rst,     // Link block held in reset.
	output reg         serdes_pd,    // Lane serializers powered down.
	output reg         link_clk_en,  // Link block clock gate enable.
	output reg         mf_rst,       // Multiframe counter held in reset.
	output reg  [7:0]  mf_count,     // Multiframe frame counter.
	output reg         mf_edge       // Multiframe boundary pulse.
);

	// Stored control registers.
	reg  [7:0]  dither_control;
	reg  [7:0]  sample_marker_control;
	reg  [7:0]  sync_rx_control;
	reg  [7:0]  serial_link_enable;
	reg  [7:0]  link_mode_select;

	// Pin synchronisers and alignment delay.
	reg  [1:0]  ts_sync;
	reg  [1:0]  sr_sync;
	reg         sr_prev;
	reg  [11:0] smp_d1;
	reg  [11:0] smp_d2;
	reg         vld_d1;
	reg         vld_d2;

	// Bus decode.
	wire [11:0] reg_idx;
	wire        wr_stb;
	reg  [31:0] rd_word;

	// Datapath outputs.
	wire [11:0] pipe_data;
	wire        pipe_vld;
	wire        pipe_mark;
	reg  [11:0] next_sample;

	wire        link_on;
	wire        sr_rise;
	wire [7:0]  dither_rst;

	assign reg_idx = wb_adr_i[13:2];
	assign link_on = serial_link_enable[`DTL_BIT_LINK_EN];
	assign sr_rise = sr_sync[1] & ~sr_prev;
	// Reset value of the dither register, split into its field copies.
	assign dither_rst = `DTL_RST_DITHER;

	dtl_wb_port u_port (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_we_i  (wb_we_i),
		.wb_sel_i (wb_sel_i),
		.rd_word  (rd_word),
		.wb_ack_o (wb_ack_o),
		.wb_dat_o (wb_dat_o),
		.wr_stb   (wr_stb)
	);

	// Register writes; unmapped indexes are acknowledged and ignored.
	// Reserved bits are stored as written, since they are read/write.
	always @(posedge clk) begin
		if (rst) begin
			dither_control        <= `DTL_RST_DITHER;
			sample_marker_control <= `DTL_RST_MARKER;
			sync_rx_control       <= `DTL_RST_SYNC_RX;
			serial_link_enable    <= `DTL_RST_LINK_EN;
			link_mode_select      <= `DTL_RST_LINK_MODE;
		end else if (wr_stb) begin
			case (reg_idx)
			`DTL_IDX_DITHER: begin
				dither_control <= wb_dat_i[7:0];
			end
			`DTL_IDX_MARKER: begin
				sample_marker_control <= wb_dat_i[7:0];
			end
			`DTL_IDX_SYNC_RX: begin
				sync_rx_control <= wb_dat_i[7:0];
			end
			`DTL_IDX_LINK_EN: begin
				serial_link_enable <= wb_dat_i[7:0];
			end
			`DTL_IDX_LINK_MODE: begin
				// Ordering against link and calibration enables is
				// left to software; the value is taken as written.
				link_mode_select <= wb_dat_i[7:0];
			end
			default: begin
				link_mode_select <= link_mode_select;
			end
			endcase
		end
	end

	// Read multiplexer; bits above the 8-bit registers read as zero.
	always @* begin
		rd_word = 32'h0000_0000;
		case (reg_idx)
		`DTL_IDX_DITHER:      rd_word[7:0] = dither_control;
		`DTL_IDX_MARKER:      rd_word[7:0] = sample_marker_control;
		`DTL_IDX_SYNC_RX:     rd_word[7:0] = sync_rx_control;
		`DTL_IDX_LINK_EN:     rd_word[7:0] = serial_link_enable;
		`DTL_IDX_LINK_MODE:   rd_word[7:0] = link_mode_select;
		`DTL_IDX_LINK_STATUS: rd_word[15:0] = {mf_count, 4'h0,
			mf_rst, serdes_pd, link_clk_en, link_rst};
		default:              rd_word = 32'h0000_0000;
		endcase
	end

	// Two flip-flops on each pin before any logic looks at it.
	always @(posedge clk) begin
		if (rst) begin
			ts_sync <= 2'h0;
			sr_sync <= 2'h0;
			sr_prev <= 1'b0;
		end else if (ce) begin
			ts_sync <= {ts_sync[0], timestamp_pin};
			sr_sync <= {sr_sync[0], sysref_pin};
			sr_prev <= sr_sync[1];
		end
	end

	// Samples wait two cycles so they meet the synchronised marker
	// that was sampled with them.
	always @(posedge clk) begin
		if (rst) begin
			smp_d1 <= 12'h000;
			smp_d2 <= 12'h000;
			vld_d1 <= 1'b0;
			vld_d2 <= 1'b0;
		end else if (ce) begin
			smp_d1 <= sample_in;
			smp_d2 <= smp_d1;
			vld_d1 <= sample_vld;
			vld_d2 <= vld_d1;
		end
	end

	// Marker rides the same delay line as its sample.
	dtl_marker_pipe u_pipe (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.din      (smp_d2),
		.din_vld  (vld_d2),
		.mark_in  (ts_sync[1]),
		.dout     (pipe_data),
		.dout_vld (pipe_vld),
		.mark_out (pipe_mark)
	);

	// The marker overwrites the LSB of the active format; in 8-bit mode
	// the sample occupies the top eight bits, so bit 4 is its LSB.
	always @* begin
		next_sample = pipe_data;
		if (sample_marker_control[`DTL_BIT_MARK_EN]) begin
			if (fmt_8bit) begin
				next_sample[4] = pipe_mark;
			end else begin
				next_sample[0] = pipe_mark;
			end
		end
	end

	// Sample output stage.
	always @(posedge clk) begin
		if (rst) begin
			sample_out     <= 12'h000;
			sample_out_vld <= 1'b0;
		end else if (ce) begin
			sample_out     <= next_sample;
			sample_out_vld <= pipe_vld;
		end
	end

	// Converter controls follow their register fields; ILA control bits are held at zero.
	// The sync receiver bit is separate so software can pair it with
	// marking itself; hardware does not force it.
	always @(posedge clk) begin
		if (rst) begin
			dither_en     <= dither_rst[`DTL_BIT_DITH_EN];
			dither_large  <= dither_rst[`DTL_BIT_DITH_AMP];
			err_to_offset <= dither_rst[`DTL_BIT_DITH_ERR];
			sync_rx_en    <= 1'b0;
			ila_ctrl_bits <= `DTL_ILA_CS;
			link_mode     <= `DTL_RST_LINK_MODE;
		end else if (ce) begin
			dither_en     <= dither_control[`DTL_BIT_DITH_EN];
			dither_large  <= dither_control[`DTL_BIT_DITH_AMP];
			err_to_offset <= dither_control[`DTL_BIT_DITH_ERR];
			sync_rx_en    <= sync_rx_control[`DTL_BIT_SYNC_RX_EN];
			ila_ctrl_bits <= `DTL_ILA_CS;
			link_mode     <= link_mode_select;
		end
	end

	// Link gating: a cleared enable resets the link, powers down the
	// serializers and stops its clocks in the same cycle.
	always @(posedge clk) begin
		if (rst) begin
			link_rst    <= 1'b0;
			serdes_pd   <= 1'b0;
			link_clk_en <= 1'b1;
			mf_rst      <= 1'b0;
		end else if (ce) begin
			link_rst    <= ~link_on;
			serdes_pd   <= ~link_on;
			link_clk_en <= link_on;
			mf_rst      <= ~link_on;
		end
	end

	// Multiframe counter; sysref realigns it only while the link runs,
	// so a disabled link keeps it parked at zero.
	always @(posedge clk) begin
		if (rst) begin
			mf_count <= 8'h00;
			mf_edge  <= 1'b0;
		end else if (ce) begin
			if (~link_on) begin
				mf_count <= 8'h00;
				mf_edge  <= 1'b0;
			end else if (sr_rise) begin
				mf_count <= 8'h00;
				mf_edge  <= 1'b1;
			end else if (mf_count == `DTL_MF_FRAMES - 8'h01) begin
				mf_count <= 8'h00;
				mf_edge  <= 1'b1;
			end else begin
				mf_count <= mf_count + 8'h01;
				mf_edge  <= 1'b0;
			end
		end
	end

endmodule

// ==== dtl_ctrl_asserts.sv ====
// Purpose: Bus, link gating and sample timing checks on dtl_ctrl.
// Assumes: Clock enable stays high while the sample latency is judged.
// Notes:   Sees only the ports of dtl_ctrl; attached by bind below.
`timescale 1ns/1ns
module dtl_ctrl_chk (
	input wire       clk,            // Clock.
	input wire       rst,            // Synchronous reset.
	input wire       ce,             // Clock enable.
	input wire       wb_cyc_i,       // Bus cycle.
	input wire       wb_stb_i,       // Bus strobe.
	input wire       wb_we_i,        // Bus write.
	input wire       wb_ack_o,       // Bus acknowledge.
	input wire       sample_vld,     // Sample valid in.
	input wire       sample_out_vld, // Sample valid out.
	input wire [1:0] ila_ctrl_bits,  // Advertised control bits.
	input wire       link_rst,       // Link held in reset.
	input wire       serdes_pd,      // Serializers down.
	input wire       link_clk_en,    // Link clock gate.
	input wire       mf_rst,         // Counter held in reset.
	input wire [7:0] mf_count,       // Frame counter.
	input wire       mf_edge         // Counter boundary pulse.
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// A taken request is answered on the next edge, and only then.
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && ce && !wb_ack_o
		|=> wb_ack_o) else $error("request not answered");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("answer without request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("answer longer than one cycle");
	// All link gating outputs follow the one enable bit together.
	link_gate_a: assert property (link_rst == serdes_pd
		&& mf_rst == link_rst && link_clk_en == !link_rst)
		else $error("link gating split");
	// The gating only moves one edge after a register write lands.
	link_cause_a: assert property ($changed(link_rst)
		|-> $past(wb_ack_o, 2))
		else $error("link gating moved without a write");
	ila_zero_a: assert property (ila_ctrl_bits == 2'h0)
		else $error("control bits advertised");
	// A disabled link keeps the counter at zero and ignores sysref.
	mf_hold_a: assert property (mf_rst && $past(mf_rst)
		|-> mf_count == 8'h00 && !mf_edge) else $error("counter ran in reset");
	mf_wrap_a: assert property (!mf_rst && ce && mf_count == 8'h1F
		|=> mf_count == 8'h00) else $error("counter did not wrap");
	vld_lat_a: assert property (ce
		|-> sample_out_vld == $past(sample_vld, 7))
		else $error("sample latency wrong");
	cover property (wb_ack_o && wb_we_i);
	cover property ($rose(link_rst));
	cover property (mf_edge);
	cover property (sample_out_vld);
endmodule
bind dtl_ctrl dtl_ctrl_chk u_dtl_ctrl_chk (.clk(clk), .rst(rst), .ce(ce),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_ack_o(wb_ack_o), .sample_vld(sample_vld),
	.sample_out_vld(sample_out_vld), .ila_ctrl_bits(ila_ctrl_bits),
	.link_rst(link_rst), .serdes_pd(serdes_pd), .link_clk_en(link_clk_en),
	.mf_rst(mf_rst), .mf_count(mf_count), .mf_edge(mf_edge));

// ==== test_dtl_ctrl.sv ====
// Purpose: Self-checking bench for the dtl_ctrl register bank.
// Assumes: Clock enable high apart from one five-cycle freeze; registers reached over Wishbone.
// Notes:   Expected values come from a register model and sample queue.
`timescale 1ns/1ns
`include "dtl_defs.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module test_dtl_ctrl;
	logic clk = 0, rst = 1, ce = 1, cyc = 0, stb = 0, wen = 0;
	logic [13:0] adr = 0;
	logic [3:0] sl = 0;
	logic [31:0] dat = 0, rdat, r, v;
	logic [11:0] s_in = 0, s_out, exp_s, e;
	logic s_vld = 0, f8 = 0, ts = 0, sref = 0, ack, o_vld, d_en, d_lg, d_er;
	logic sync_en, l_rst, pd, l_ce, m_rst, m_edge, mk = 0;
	logic [1:0] ila;
	logic [7:0] l_mode, m_cnt;
	logic [31:0] mdl [int];
	logic [11:0] q [$];
	int n_mismatch = 0, checks_done = 0, i;
	dtl_ctrl u_dtl_ctrl (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(sl),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .sample_in(s_in),
		.sample_vld(s_vld), .fmt_8bit(f8), .timestamp_pin(ts),
		.sysref_pin(sref), .sample_out(s_out), .sample_out_vld(o_vld),
		.dither_en(d_en), .dither_large(d_lg), .err_to_offset(d_er),
		.sync_rx_en(sync_en), .ila_ctrl_bits(ila), .link_mode(l_mode),
		.link_rst(l_rst), .serdes_pd(pd), .link_clk_en(l_ce),
		.mf_rst(m_rst), .mf_count(m_cnt), .mf_edge(m_edge));
	always #2 clk = ~clk;
	// Every output sample is matched against the oldest one sent.
	always @(posedge clk) begin
		if (o_vld === 1'b1) begin
			exp_s = q.pop_front();
			`CHK(s_out, exp_s)
		end
	end
	// Holds the request until ack is seen, then leaves one idle edge.
	task automatic wb(input bit we, input [11:0] idx, input [31:0] d,
		input [3:0] sel);
		@(posedge clk);
		{cyc, stb, wen, adr, dat, sl} <= {2'b11, we, idx, 2'b00, d, sel};
		do begin @(posedge clk); end while (ack !== 1'b1);
		r = rdat;
		{cyc, stb, wen} <= 3'b000;
		@(posedge clk);
	endtask
	task automatic wr(input [11:0] idx, input [31:0] d);
		wb(1, idx, d, 4'h1);
		if (mdl.exists(idx)) mdl[idx] = d & 32'h0000_00FF;
		@(posedge clk);
	endtask
	task automatic rdchk(input [11:0] idx);
		wb(0, idx, 32'h0000_0000, 4'hF);
		`CHK(r, mdl.exists(idx) ? mdl[idx] : 32'h0000_0000)
	endtask
	// The marker replaces bit 0, or bit 4 when the 8-bit format is set.
	task automatic stream(input int n);
		repeat (n) begin
			@(posedge clk);
			e = $urandom;
			v = $urandom;
			s_in <= e;
			ts <= v[0];
			s_vld <= 1'b1;
			if (mk) e[f8 ? 4 : 0] = v[0];
			q.push_back(e);
		end
		@(posedge clk);
		s_vld <= 1'b0;
		repeat (12) @(posedge clk);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		mdl[`DTL_IDX_DITHER] = `DTL_RST_DITHER;
		mdl[`DTL_IDX_MARKER] = `DTL_RST_MARKER;
		mdl[`DTL_IDX_SYNC_RX] = `DTL_RST_SYNC_RX;
		mdl[`DTL_IDX_LINK_EN] = `DTL_RST_LINK_EN;
		mdl[`DTL_IDX_LINK_MODE] = `DTL_RST_LINK_MODE;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		void'($urandom(50779));
		foreach (mdl[k]) rdchk(k[11:0]);
		wb(0, `DTL_IDX_LINK_STATUS, 32'h0000_0000, 4'hF);
		`CHK(r[7:0], 8'h02)
		$display("done: reset values");
		// Unmapped places read zero; a write to an unmapped index is dropped.
		wb(1, 12'h100, 32'h0000_00FF, 4'h1);
		rdchk(12'h100);
		$display("done: map and refusals");
		for (i = 0; i < 8; i++) begin
			v = $urandom;
			v[2:0] = i[2:0];
			wr(`DTL_IDX_DITHER, v);
			rdchk(`DTL_IDX_DITHER);
			`CHK({d_er, d_lg, d_en}, v[2:0])
		end
		$display("done: dither codes");
		// The link is held off while its mode changes and enabled last.
		wr(`DTL_IDX_LINK_EN, 32'h0000_0000);
		`CHK({m_rst, pd, l_ce, l_rst}, 4'b1101)
		wb(1, `DTL_IDX_LINK_MODE, 32'h0000_0055, 4'hE);
		rdchk(`DTL_IDX_LINK_MODE);
		wr(`DTL_IDX_LINK_MODE, $urandom);
		rdchk(`DTL_IDX_LINK_MODE);
		`CHK(l_mode, mdl[`DTL_IDX_LINK_MODE][7:0])
		sref <= 1'b1;
		repeat (6) @(posedge clk);
		sref <= 1'b0;
		wb(0, `DTL_IDX_LINK_STATUS, 32'h0000_0000, 4'hF);
		`CHK(r, 32'h0000_000D)
		wr(`DTL_IDX_LINK_EN, 32'h0000_0001);
		`CHK({m_rst, pd, l_ce, l_rst}, 4'b0010)
		// A running counter is realigned three edges after the pin rises.
		sref <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK({m_edge, m_cnt}, 9'h100)
		repeat (8) @(posedge clk);
		`CHK({m_edge, m_cnt}, 9'h008)
		// A low clock enable freezes the counter where it stands.
		ce <= 1'b0;
		sref <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK(m_cnt, 8'h09)
		ce <= 1'b1;
		repeat (40) @(posedge clk);
		$display("done: link gating");
		for (i = 0; i < 4; i++) begin
			mk = i[0];
			wr(`DTL_IDX_MARKER, {31'h0, mk});
			wr(`DTL_IDX_SYNC_RX, {31'h0, mk});
			`CHK(sync_en, mk)
			`CHK(ila, 2'h0)
			f8 <= i[1];
			stream(20);
		end
		`CHK(q.size(), 0)
		$display("done: sample marker");
		wrap_up();
	end
endmodule
